//--- fcff_pkg.sv
// Shared constants and types for the fall-through FIFO core
package fcff_pkg;
  // ----------------------------------------
  // Sizes and presets
  // ----------------------------------------
  localparam int          DATA_W      = 36;
  localparam int          DEPTH_DEF   = 512;
  localparam logic [10:0] PRESET_LOW  = 11'h008;
  localparam logic [10:0] PRESET_HIGH = 11'h040;
  // Writes still in flight while input_ready settles through its two stages
  localparam int          IR_MARGIN   = 2;
  // ----------------------------------------
  // Flag-select encodings at reset release
  // ----------------------------------------
  localparam logic [1:0]  FS_SERIAL   = 2'h3;
  localparam logic [1:0]  FS_P64      = 2'h2;
  localparam logic [1:0]  FS_P8       = 2'h1;
  localparam logic [1:0]  FS_PAR     = 2'h0;
  // ----------------------------------------
  // Values during reset
  // ----------------------------------------
  localparam logic        IR_RST      = 1'b0;
  localparam logic        OR_RST      = 1'b0;
  localparam logic        AE_N_RST    = 1'b0;
  localparam logic        AF_N_RST    = 1'b1;
  localparam logic        MBF_N_RST   = 1'b1;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {ST_HOLD, ST_SERIAL, ST_PAR_HIGH, ST_PAR_LOW, ST_RUN} fcff_state_t;
  typedef struct packed {
    logic              cs_n;
    logic              dir;
    logic              go;
    logic              mb;
    logic [DATA_W-1:0] data;
  } fcff_a_pins_t;
  typedef struct packed {
    logic cs_n;
    logic dir;
    logic go;
    logic mb;
  } fcff_b_pins_t;
endpackage

//--- fcff_sync2.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module fcff_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_q;

  // No reset here: reset itself passes through this path
  always_ff @(posedge clk_in) begin
    meta_q <= d_in;
    q_out  <= meta_q;
  end
endmodule

//--- fcff_buf2.sv
// Two-entry valid/ready buffer in the write path
`timescale 1ns/1ps
module fcff_buf2 #(
  parameter int W = 36
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic      [W-1:0] out_data_out,
  output logic      [1:0]   count_out
);
  logic [W-1:0] slot_q [2];
  logic         wp_q;
  logic         rp_q;
  logic [1:0]   cnt_q;
  wire          push = in_valid_in && in_ready_out;
  wire          pop  = out_valid_out && out_ready_in;

  assign in_ready_out  = (cnt_q != 2'h2);
  assign out_valid_out = (cnt_q != 2'h0);
  assign out_data_out  = slot_q[rp_q];
  assign count_out     = cnt_q;

  always_ff @(posedge clk_in) begin
    if (push) begin
      slot_q[wp_q] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      wp_q  <= wp_q ^ push;
      rp_q  <= rp_q ^ pop;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

//--- fcff_top.sv
// First-word-fall-through FIFO core with programmable almost flags
`timescale 1ns/1ps
// What this block does
// R1: Outside party holds reset low for at least four clock edges.
// R2: Reset may change anytime; it is synchronised before use.
// R3: Reset clears pointers; ready flags low, almost_empty low, almost_full high, mail flags high.
// R4: input_ready rises no earlier than two clocks after reset release.
// R5: Outside party resets the FIFO before its first write.
// R6: First word into an empty FIFO falls through without a read.
// R7: Flag selects at reset release choose serial, preset 64, preset 8 or parallel.
// R8: Preset modes load both offsets; input_ready rises two edges later.
// R9: Parallel mode: first two writes load high then low offset.
// R10: Parallel offsets use low data bits, top bit as MSB, range 1..depth-4.
// R11: Serial mode shifts one offset bit per clock while enable is low.
// R12: Serial load is 2*log2(depth) bits, high offset MSB first.
// R13: Serial mode: input_ready rises on the edge after the last bit.
// R14: Port A data drives only while chip select and direction are low.
// R15: Write when selected, direction high, go high, mailbox low, input_ready high.
// R16: Port B data drives only while chip select low and direction high.
// R17: Read when selected, direction high, go high, mailbox low, output_ready high.
// R18: Output register autoloads while output_ready low; otherwise advances on reads.
// R19: input_ready and both almost flags pass two flip-flop stages before leaving; output_ready is set through two (avail_q, or_q); mail flags pass one.
// R20: output_ready low keeps previous word and ignores reads.
// R21: Write into empty FIFO reaches output register on third edge after.
// R22: input_ready low means no room; writes are then ignored.
// R23: almost_empty low while count is at most the low offset.
// R24: almost_full low while count reaches depth minus high offset.
// R25: Depth parameter sets pointer, offset and serial widths.
module fcff_top #(
  parameter int DEPTH = fcff_pkg::DEPTH_DEF
) (
  input  wire logic                        clk_in,
  input  wire logic                        nrst_in,
  input  wire logic                        flag_select0_serial_data_in,
  input  wire logic                        flag_select1_serial_enable_in,
  input  wire logic                        port_a_chip_sel_n_in,
  input  wire logic                        port_a_direction_in,
  input  wire logic                        port_a_go_in,
  input  wire logic                        port_a_mailbox_sel_in,
  input  wire logic [fcff_pkg::DATA_W-1:0] port_a_data_in,
  output logic      [fcff_pkg::DATA_W-1:0] port_a_data_out,
  output logic                             port_a_data_oe_out,
  input  wire logic                        port_b_chip_sel_n_in,
  input  wire logic                        port_b_direction_in,
  input  wire logic                        port_b_go_in,
  input  wire logic                        port_b_mailbox_sel_in,
  output logic      [fcff_pkg::DATA_W-1:0] port_b_data_out,
  output logic                             port_b_data_oe_out,
  output logic                             input_ready_out,
  output logic                             output_ready_out,
  output logic                             almost_empty_n_out,
  output logic                             almost_full_n_out,
  output logic                             mail_to_b_flag_n_out,
  output logic                             mail_to_a_flag_n_out
);
  import fcff_pkg::*;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  // R25: depth-derived widths
  localparam int         AW       = $clog2(DEPTH);
  localparam int         OW       = AW;
  localparam int         SBITS    = 2 * OW;
  localparam int         CW       = $clog2(SBITS);
  localparam int         SYNC_W   = 3 + $bits(fcff_a_pins_t) + $bits(fcff_b_pins_t);
  localparam logic [AW:0] DEPTH_V  = (AW+1)'(DEPTH);
  localparam logic [AW:0] IR_LIMIT = (AW+1)'(DEPTH - IR_MARGIN);
  localparam logic [CW-1:0] SER_LAST = CW'(SBITS - 1);

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  fcff_a_pins_t     a_raw;
  fcff_b_pins_t     b_raw;
  fcff_a_pins_t     a_s;
  fcff_b_pins_t     b_s;
  logic [SYNC_W-1:0] sync_bus;
  logic             rst_n_s;
  logic [1:0]       fs_s;

  assign a_raw = {port_a_chip_sel_n_in, port_a_direction_in, port_a_go_in,
                  port_a_mailbox_sel_in, port_a_data_in};
  assign b_raw = {port_b_chip_sel_n_in, port_b_direction_in, port_b_go_in,
                  port_b_mailbox_sel_in};

  // R2: async reset pin retimed with the other pins
  fcff_sync2 #(.WIDTH(SYNC_W)) u_sync (
    .clk_in (clk_in),
    .d_in   ({nrst_in, flag_select1_serial_enable_in, flag_select0_serial_data_in,
              a_raw, b_raw}),
    .q_out  (sync_bus)
  );
  assign {rst_n_s, fs_s, a_s, b_s} = sync_bus;

  // ----------------------------------------
  // State
  // ----------------------------------------
  wire                rst = !rst_n_s;
  logic               rst_prev_q;
  fcff_state_t        st_q;
  logic [OW-1:0]      high_q;
  logic [OW-1:0]      low_q;
  logic [SBITS-1:0]   sh_q;
  logic [CW-1:0]      ser_cnt_q;
  logic [AW:0]        wr_ptr_q;
  logic [AW:0]        rd_ptr_q;
  logic [DATA_W-1:0]  mem_q [DEPTH];
  logic [DATA_W-1:0]  out_q;
  logic               avail_q;
  logic               or_q;
  logic               ir_s1_q;
  logic               ir_q;
  logic               ae_s1_q;
  logic               ae_q;
  logic               af_s1_q;
  logic               af_q;
  logic               mbf_q;
  logic               buf_in_ready;
  logic               buf_out_valid;
  logic [DATA_W-1:0]  buf_out_data;
  logic [1:0]         buf_cnt;

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  wire              rel       = rst_n_s && !rst_prev_q;
  wire              setup_st  = (st_q == ST_PAR_HIGH) || (st_q == ST_PAR_LOW);
  // R15: port A write qualifier
  wire              a_sel     = !a_s.cs_n && a_s.dir && a_s.go && !a_s.mb;
  // R22: nothing is taken while input_ready is low
  wire              wr_fire   = a_sel && ir_q && buf_in_ready;
  wire              push      = wr_fire && (st_q == ST_RUN);
  wire [AW:0]       mem_cnt   = wr_ptr_q - rd_ptr_q;
  wire [AW:0]       total     = mem_cnt + (AW+1)'(buf_cnt);
  // Memory full stalls the buffer, so its two slots catch late writes
  wire              drain     = buf_out_valid && (mem_cnt != DEPTH_V);
  // R17: port B read qualifier
  wire              b_sel     = !b_s.cs_n && b_s.dir && b_s.go && !b_s.mb;
  // R20: reads ignored while output_ready is low
  wire              rd_fire   = b_sel && or_q;
  wire              avail     = (wr_ptr_q != rd_ptr_q) && avail_q;
  // R18: autoload when empty register, else only on a read
  wire              load      = avail && (!or_q || rd_fire);
  wire [AW:0]       rd_ptr_d  = rd_ptr_q + (AW+1)'(load);
  // R11: one bit per clock while serial enable is low
  wire              ser_shift = (st_q == ST_SERIAL) && !fs_s[1];
  wire              ser_last  = ser_shift && (ser_cnt_q == SER_LAST);
  wire [SBITS-1:0]  sh_d      = {sh_q[SBITS-2:0], fs_s[0]};
  wire [AW:0]       af_lim    = DEPTH_V - (AW+1)'(high_q);
  // R13: serial done feeds input_ready one edge early
  wire              ir_raw    = ((st_q == ST_RUN) || setup_st || ser_last)
                                && (total < IR_LIMIT) && buf_in_ready;

  // ----------------------------------------
  // Write buffer
  // ----------------------------------------
  fcff_buf2 #(.W(DATA_W)) u_buf (
    .clk_in        (clk_in),
    .nrst_in       (rst_n_s),
    .in_valid_in   (push),
    .in_ready_out  (buf_in_ready),
    .in_data_in    (a_s.data),
    .out_valid_out (buf_out_valid),
    .out_ready_in  (drain),
    .out_data_out  (buf_out_data),
    .count_out     (buf_cnt)
  );

  // ----------------------------------------
  // Mode and offset programming
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    rst_prev_q <= rst_n_s;
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin
      st_q      <= ST_HOLD;
      ser_cnt_q <= '0;
    end else begin
      case (st_q)
        // R7: mode picked on the release edge
        ST_HOLD: begin
          if (rel) begin
            case (fs_s)
              FS_SERIAL: st_q <= ST_SERIAL;
              FS_PAR:    st_q <= ST_PAR_HIGH;
              default:   st_q <= ST_RUN;
            endcase
          end
        end
        ST_SERIAL: begin
          if (ser_shift) begin
            ser_cnt_q <= ser_cnt_q + CW'(1);
          end
          if (ser_last) begin
            st_q <= ST_RUN;
          end
        end
        ST_PAR_HIGH: begin
          if (wr_fire) begin
            st_q <= ST_PAR_LOW;
          end
        end
        ST_PAR_LOW: begin
          if (wr_fire) begin
            st_q <= ST_RUN;
          end
        end
        ST_RUN:  st_q <= ST_RUN;
        default: st_q <= ST_HOLD;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    // R8: presets loaded automatically
    if (st_q == ST_HOLD && rel && fs_s == FS_P64) begin
      high_q <= PRESET_HIGH[OW-1:0];
      low_q  <= PRESET_HIGH[OW-1:0];
    end else if (st_q == ST_HOLD && rel && fs_s == FS_P8) begin
      high_q <= PRESET_LOW[OW-1:0];
      low_q  <= PRESET_LOW[OW-1:0];
    // R9: first write is the high offset, second the low
    // R10: low data bits, top one as MSB; range kept by the writer
    end else if (st_q == ST_PAR_HIGH && wr_fire) begin
      high_q <= a_s.data[OW-1:0];
    end else if (st_q == ST_PAR_LOW && wr_fire) begin
      low_q <= a_s.data[OW-1:0];
    // R12: high offset MSB first, low offset LSB last
    end else if (ser_last) begin
      high_q <= sh_d[SBITS-1:OW];
      low_q  <= sh_d[OW-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (ser_shift) begin
      sh_q <= sh_d;
    end
  end

  // ----------------------------------------
  // Memory and pointers
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (drain) begin
      mem_q[wr_ptr_q[AW-1:0]] <= buf_out_data;
    end
  end

  // R3: pointers cleared, flags forced
  always_ff @(posedge clk_in) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      avail_q  <= 1'b0;
      or_q     <= OR_RST;
      mbf_q    <= MBF_N_RST;
    end else begin
      wr_ptr_q <= wr_ptr_q + (AW+1)'(drain);
      rd_ptr_q <= rd_ptr_d;
      // R21: first stage sees the word one edge after it lands
      avail_q  <= (wr_ptr_q != rd_ptr_d);
      // R6: fall through on the second stage
      or_q     <= load || (or_q && !rd_fire);
      mbf_q    <= MBF_N_RST;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin
      out_q <= '0;
    end else if (load) begin
      out_q <= mem_q[rd_ptr_q[AW-1:0]];
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // R19: two stages per flag
  // R4: release edge then two more before input_ready
  always_ff @(posedge clk_in) begin
    if (rst) begin
      ir_s1_q <= IR_RST;
      ir_q    <= IR_RST;
      ae_s1_q <= AE_N_RST;
      ae_q    <= AE_N_RST;
      af_s1_q <= AF_N_RST;
      af_q    <= AF_N_RST;
    end else begin
      ir_s1_q <= ir_raw;
      ir_q    <= ir_s1_q;
      // R23: output register word already counts as read
      ae_s1_q <= (mem_cnt > (AW+1)'(low_q));
      ae_q    <= ae_s1_q;
      // R24: low once count reaches depth minus high offset
      af_s1_q <= (mem_cnt < af_lim);
      af_q    <= af_s1_q;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // R14: port A drives only when selected for reading
  assign port_a_data_oe_out   = !a_s.cs_n && !a_s.dir;
  // Mailbox path is absent, so port A reads back zero
  assign port_a_data_out      = '0;
  // R16: port B direction sense is inverted
  assign port_b_data_oe_out   = !b_s.cs_n && b_s.dir;
  assign port_b_data_out      = out_q;
  assign input_ready_out      = ir_q;
  assign output_ready_out     = or_q;
  assign almost_empty_n_out   = ae_q;
  assign almost_full_n_out    = af_q;
  assign mail_to_b_flag_n_out = mbf_q;
  assign mail_to_a_flag_n_out = mbf_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_empty_then_write;
    (!or_q && wr_ptr_q == rd_ptr_q) ##1 (wr_ptr_q != rd_ptr_q);
  endsequence

  sequence s_preset_release;
    (st_q == ST_HOLD) && rel && (fs_s == FS_P64 || fs_s == FS_P8);
  endsequence

  property p_reset_flags;
    @(posedge clk_in) disable iff (1'b0)
      rst |=> (!ir_q && !or_q && !ae_q && af_q && mbf_q && wr_ptr_q == '0);
  endproperty
  a_reset_flags: assert property (p_reset_flags) else $error("reset flags wrong"); // R3

  property p_preset_ir;
    @(posedge clk_in) disable iff (rst)
      s_preset_release |=> !ir_q ##1 !ir_q ##1 ir_q;
  endproperty
  a_preset_ir: assert property (p_preset_ir) else $error("preset ready timing"); // R8

  property p_serial_ir;
    @(posedge clk_in) disable iff (rst)
      ser_last |=> !ir_q ##1 ir_q;
  endproperty
  a_serial_ir: assert property (p_serial_ir) else $error("serial ready timing"); // R13

  property p_mode_sel;
    @(posedge clk_in) disable iff (rst)
      (st_q == ST_HOLD && rel && fs_s == FS_SERIAL) |=> (st_q == ST_SERIAL) && !ir_q;
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("serial mode not chosen"); // R7

  property p_par_load;
    @(posedge clk_in) disable iff (rst)
      (st_q == ST_PAR_HIGH && wr_fire) |=>
        (high_q == $past(a_s.data[OW-1:0])) && (st_q == ST_PAR_LOW) && (buf_cnt == 2'h0);
  endproperty
  a_par_load: assert property (p_par_load) else $error("high offset not loaded"); // R9

  property p_no_room;
    @(posedge clk_in) disable iff (rst)
      !ir_q |=> (total <= $past(total)) && (mem_cnt <= DEPTH_V);
  endproperty
  a_no_room: assert property (p_no_room) else $error("write accepted when full"); // R22

  property p_fall_through;
    @(posedge clk_in) disable iff (rst)
      s_empty_then_write |=> !or_q ##1 or_q;
  endproperty
  a_fall_through: assert property (p_fall_through) else $error("fall through late"); // R21

  property p_hold_word;
    @(posedge clk_in) disable iff (rst)
      (or_q && !rd_fire) |=> or_q && $stable(out_q);
  endproperty
  a_hold_word: assert property (p_hold_word) else $error("word changed without read"); // R18

  property p_ae_level;
    @(posedge clk_in) disable iff (rst)
      (mem_cnt > (AW+1)'(low_q)) [*2] |=> almost_empty_n_out;
  endproperty
  a_ae_level: assert property (p_ae_level) else $error("almost_empty stuck low"); // R23

  property p_af_level;
    @(posedge clk_in) disable iff (rst)
      (mem_cnt >= af_lim) [*2] |=> !almost_full_n_out;
  endproperty
  a_af_level: assert property (p_af_level) else $error("almost_full not low"); // R24
endmodule

//--- fcff_reader.sv
// Port B reader model that drains the FIFO and logs each new word
`timescale 1ns/1ps
module fcff_reader
  import fcff_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              en_in,
  input  wire logic              or_in,
  input  wire logic [DATA_W-1:0] data_in,
  output logic                   cs_n_out,
  output logic                   dir_out,
  output logic                   go_out,
  output logic                   mb_out
);
  logic [DATA_W-1:0] last_q;
  logic [DATA_W-1:0] got[$];
  assign cs_n_out = 1'b0;
  assign dir_out  = 1'b1;
  assign mb_out   = 1'b0;
  initial go_out = 1'b0;
  initial last_q = '0;
  // read request
  // Stalls simply hold go low; the FIFO must keep every word meanwhile
  always @(posedge clk_in) begin
    go_out <= #1 en_in;
  end
  // Words are distinct, so a change while ready marks a new word
  // Sampled mid-cycle, where the registered outputs have settled
  always @(negedge clk_in) begin
    if (or_in === 1'b1 && data_in !== last_q) got.push_back(data_in);
    last_q = data_in;
  end
endmodule

//--- fcff_top_bench.sv
// Self-checking testbench for the fall-through FIFO core
`timescale 1ns/1ps
module fcff_top_bench;
  import fcff_pkg::*;
  localparam int D = 512;
  logic              clk_in = 1'b0;
  logic              nrst_in = 1'b0;
  logic              fs0 = 1'b0;
  logic              fs1 = 1'b0;
  logic              a_cs_n = 1'b0;
  logic              a_dir = 1'b1;
  logic              a_go = 1'b0;
  logic              a_mb = 1'b0;
  logic [DATA_W-1:0] a_data = '0;
  logic              rd_en = 1'b0;
  logic              b_cs_n, b_dir, b_go, b_mb;
  logic [DATA_W-1:0] b_data;
  logic [DATA_W-1:0] a_dout;
  logic              b_oe, a_oe, ir, ordy, ae_n, af_n, mb1_n, mb2_n;
  int                miscompares = 0;
  int                num_checks = 0;
  always #2.5 clk_in = ~clk_in;
  fcff_top #(.DEPTH(D)) uut (
    .clk_in(clk_in), .nrst_in(nrst_in),
    .flag_select0_serial_data_in(fs0), .flag_select1_serial_enable_in(fs1),
    .port_a_chip_sel_n_in(a_cs_n), .port_a_direction_in(a_dir),
    .port_a_go_in(a_go), .port_a_mailbox_sel_in(a_mb),
    .port_a_data_in(a_data), .port_a_data_out(a_dout), .port_a_data_oe_out(a_oe),
    .port_b_chip_sel_n_in(b_cs_n), .port_b_direction_in(b_dir),
    .port_b_go_in(b_go), .port_b_mailbox_sel_in(b_mb),
    .port_b_data_out(b_data), .port_b_data_oe_out(b_oe),
    .input_ready_out(ir), .output_ready_out(ordy),
    .almost_empty_n_out(ae_n), .almost_full_n_out(af_n),
    .mail_to_b_flag_n_out(mb1_n), .mail_to_a_flag_n_out(mb2_n));
  fcff_reader rdr (
    .clk_in(clk_in), .en_in(rd_en), .or_in(ordy), .data_in(b_data),
    .cs_n_out(b_cs_n), .dir_out(b_dir), .go_out(b_go), .mb_out(b_mb));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wait_ir;
    for (int k = 0; k < 40 && ir !== 1'b1; k++) cyc(1);
  endtask
  // Back-to-back writes while input_ready stays high
  task automatic burst(input int n, input logic [DATA_W-1:0] base, input logic mb);
    int i;
    i = 0;
    while (i < n && ir === 1'b1) begin
      a_go = 1'b1;
      a_mb = mb;
      a_data = base + DATA_W'(i);
      i++;
      cyc(1);
    end
    a_go = 1'b0;
    a_mb = 1'b0;
    cyc(1);
  endtask
  task automatic do_reset(input logic [1:0] fs);
    rd_en = 1'b0;
    nrst_in = 1'b0;
    {fs1, fs0} = fs;
    cyc(12);
    rdr.got.delete();
    chk({ir, ordy, ae_n, af_n, mb1_n, mb2_n}, 6'b000111);
    nrst_in = 1'b1;
    cyc(2);
    chk(ir, 1'b0);
    // Selects held past the synchronised release edge
    cyc(4);
    fs1 = 1'b1;
    if (fs != FS_SERIAL) begin
      wait_ir();
      chk(ir, 1'b1);
    end
  endtask
  task automatic drained(input logic [DATA_W-1:0] base, input int n);
    for (int k = 0; k < n; k++) chk(rdr.got[k], base + DATA_W'(k));
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    // reset held for twelve edges before any write
    do_reset(FS_P8);
    a_dir = 1'b0;
    cyc(4);
    chk(a_oe, 1'b1);
    chk(a_dout, 36'h0_0000_0000);
    a_dir = 1'b1;
    cyc(4);
    chk(a_oe, 1'b0);
    chk(b_oe, 1'b1);
    burst(1, 36'h1_0000_0000, 1'b0);
    for (int k = 0; k < 20 && ordy !== 1'b1; k++) cyc(1);
    chk(ordy, 1'b1);
    chk(b_data, 36'h1_0000_0000);
    burst(1, 36'hf_0000_0000, 1'b1);
    burst(10, 36'h1_0000_0001, 1'b0);
    cyc(10);
    chk(ae_n, 1'b1);
    rd_en = 1'b1;
    cyc(60);
    chk(DATA_W'(rdr.got.size()), 36'h0_0000_000b);
    drained(36'h1_0000_0000, 11);
    chk(ordy, 1'b0);
    chk(b_data, 36'h1_0000_000a);
    $display("test fall_through done");
    rd_en = 1'b0;
    rdr.got.delete();
    burst(600, 36'h2_0000_0000, 1'b0);
    cyc(10);
    chk(ir, 1'b0);
    chk(af_n, 1'b0);
    rd_en = 1'b1;
    cyc(1500);
    chk(DATA_W'(rdr.got.size() >= D - 4), 36'h1);
    drained(36'h2_0000_0000, rdr.got.size());
    chk(af_n, 1'b1);
    $display("test fill_drain done");
    do_reset(FS_P64);
    burst(10, 36'h3_0000_0000, 1'b0);
    cyc(10);
    chk(ae_n, 1'b0);
    $display("test preset64 done");
    do_reset(FS_PAR);
    burst(1, 36'h0_0000_000c, 1'b0);
    burst(1, 36'h0_0000_0002, 1'b0);
    burst(4, 36'h4_0000_0000, 1'b0);
    cyc(12);
    chk(b_data, 36'h4_0000_0000);
    chk(ae_n, 1'b1);
    $display("test parallel done");
    do_reset(FS_SERIAL);
    // high offset 5 then low offset 3, top bit first
    for (int b = 17; b >= 1; b--) begin
      fs0 = 1'(({9'd5, 9'd3} >> b) & 18'h1);
      fs1 = 1'b0;
      cyc(1);
    end
    fs1 = 1'b1;
    cyc(6);
    chk(ir, 1'b0);
    fs0 = 1'b1;
    fs1 = 1'b0;
    cyc(1);
    fs1 = 1'b1;
    wait_ir();
    chk(ir, 1'b1);
    burst(5, 36'h5_0000_0000, 1'b0);
    cyc(10);
    chk(ae_n, 1'b1);
    $display("test serial done");
    complete_run();
  end
  initial begin
    #60us;
    miscompares++;
    $display("ERROR %0t watchdog expired", $time);
    complete_run();
  end
endmodule
